// ---- pkg/pbm_pkg.sv ----
// constants shared by the port-b low-half / strobe pin function selector
// assumes a 32-bit avalon-mm slave with word addressing and a 10 MHz clock

package pbm_pkg;

    // *************************************************************
    // bus geometry and register map
    // *************************************************************
    localparam int unsigned PBM_ADDR_W = 4;
    localparam int unsigned PBM_DATA_W = 32;
    localparam int unsigned PBM_BE_W = 4;
    localparam logic [3:0] PBM_PORTSEL_IDX = 4'h0; // port_b_low_function_select
    localparam logic [3:0] PBM_STROBE_IDX = 4'h1;  // strobe_pin_function_select

    // *************************************************************
    // field layout and reset values
    // *************************************************************
    localparam int unsigned PBM_PINS = 8;
    localparam int unsigned PBM_MODE_W = 2;
    localparam logic [15:0] PBM_PORTSEL_RST = 16'h0000;
    localparam logic [15:0] PBM_STROBE_RST = 16'h5FFF;
    localparam int unsigned PBM_STROBE_FLD_LSB = 12;
    localparam int unsigned PBM_UPPER_STROBE_LSB = 14;
    localparam int unsigned PBM_LOWER_STROBE_LSB = 12;
    localparam logic [3:0] PBM_STROBE_FLD_RST = 4'h5;
    localparam logic [11:0] PBM_STROBE_RSVD_ONES = 12'hFFF;

    // *************************************************************
    // mode codes
    // *************************************************************
    localparam logic [1:0] PBM_MODE_GPIO = 2'h0;
    localparam logic [1:0] PBM_MODE_ALT_IN = 2'h1;  // clock input, reserved on most pins
    localparam logic [1:0] PBM_MODE_ALT = 2'h2;
    localparam logic [1:0] PBM_MODE_PATTERN = 2'h3;
    localparam logic [1:0] PBM_STROBE_CS = 2'h1;
    localparam logic [1:0] PBM_STROBE_CAS = 2'h2;

    typedef enum logic [1:0]
    {
        PBM_IDLE = 2'b01,
        PBM_ACK = 2'b10
    } pbm_bus_state_e;

endpackage

// ---- verilog/pbm_pin_cell.sv ----
// one multiplexed port pin: picks the driver and routes the input back
// assumes pin_sync_i is already synchronised to mclk_i

module pbm_pin_cell
#(
    parameter bit CLK_IN_EN = 1'b0 // code 01 is a timer clock input
)
(
    input wire logic mclk_i,           // system clock
    input wire logic reset_i,          // power-on reset, async high
    input wire logic [1:0] mode_i,     // pin mode field
    input wire logic gpio_do_i,        // general i/o output data
    input wire logic gpio_oe_i,        // general i/o drive enable
    input wire logic alt_do_i,         // timer output data
    input wire logic alt_oe_i,         // timer drive enable
    input wire logic pattern_i,        // timing-pattern output data
    input wire logic pin_sync_i,       // synchronised pin level
    output logic pin_o,                // pin output level
    output logic pin_oe_n_o,           // low while driving the pin
    output logic gpio_di_o,            // pin level to port logic
    output logic alt_di_o,             // pin level to timer capture
    output logic clk_in_o              // pin level to timer clock
);
    import pbm_pkg::*;

    logic do_d, do_q, oen_d, oen_q, gdi_d, gdi_q, adi_d, adi_q, cki_d, cki_q;

    // *************************************************************
    // function select
    // *************************************************************
    // reserved code releases the pin so nothing fights on the board
    always_comb
    begin
        gdi_d = pin_sync_i;
        adi_d = (mode_i == PBM_MODE_ALT) ? pin_sync_i : 1'b0;
        cki_d = (CLK_IN_EN && mode_i == PBM_MODE_ALT_IN) ? pin_sync_i : 1'b0;
        unique case (mode_i)
            PBM_MODE_GPIO:
            begin
                do_d = gpio_do_i;
                oen_d = ~gpio_oe_i;
            end
            PBM_MODE_ALT_IN:
            begin
                do_d = 1'b0;
                oen_d = 1'b1;
            end
            PBM_MODE_ALT:
            begin
                do_d = alt_do_i;
                oen_d = ~alt_oe_i;
            end
            PBM_MODE_PATTERN:
            begin
                do_d = pattern_i;
                oen_d = 1'b0;
            end
        endcase
    end

    // output flops, released at power-on
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            do_q <= 1'b0;
            oen_q <= 1'b1;
            gdi_q <= 1'b0;
            adi_q <= 1'b0;
            cki_q <= 1'b0;
        end
        else
        begin
            do_q <= do_d;
            oen_q <= oen_d;
            gdi_q <= gdi_d;
            adi_q <= adi_d;
            cki_q <= cki_d;
        end
    end

    assign pin_o = do_q;
    assign pin_oe_n_o = oen_q;
    assign gpio_di_o = gdi_q;
    assign alt_di_o = adi_q;
    assign clk_in_o = cki_q;

    // *************************************************************
    // checks
    // *************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    gpio_path_a: assert property (
        mode_i == PBM_MODE_GPIO |=> pin_o == $past(gpio_do_i) && pin_oe_n_o == !$past(gpio_oe_i))
        else $error("general i/o path not on pin");
    pattern_path_a: assert property (
        mode_i == PBM_MODE_PATTERN |=> pin_o == $past(pattern_i) && !pin_oe_n_o)
        else $error("pattern output not driven");
    capture_path_a: assert property (
        mode_i == PBM_MODE_ALT |=> alt_di_o == $past(pin_sync_i) && pin_o == $past(alt_do_i))
        else $error("timer path not routed");
endmodule

// ---- verilog/pbm_pin_select.sv ----
// pin function selector for port-b pins 7..0 and the two strobe pins
// assumes port, timer, pattern and bus-state logic outside, all on mclk_i
// Behaviour
// - pin 7: 00 i/o, 01 timer clock d in, 10 compare xb4, 11 pattern
// - pin 6: 00 i/o, 01 timer clock c in, 10 compare xa4, 11 pattern
// - pins 5,4: 00 i/o, 10 timer4 capture/compare b/a, 11 pattern, 01 reserved
// - pins 3,2: 00 i/o, 10 timer3 capture/compare b/a, 11 pattern, 01 reserved
// - pins 1,0: 00 i/o, 10 timer2 capture/compare b/a, 11 pattern, 01 reserved
// - pin n mode sits in bits 2n+1:2n, all read/write
// - power-on clears the port select register; manual reset keeps it
// - strobe select register is 16 bits, 0x5FFF after power-on
// - strobe select register survives manual reset, standby and sleep
// - bits 15:14: 01 chip select one, 10 upper column strobe
// - bits 13:12: 01 chip select three, 10 lower column strobe
// - strobe fields read/write, pin follows field at once (here the strobe pin is registered, so it follows one mclk_i edge later)
// - strobe register bits 11:0 always read as ones
//
// Added by the designer: the address map and register access over Avalon-MM.

module pbm_pin_select
(
    input wire logic mclk_i,                                  // 10 MHz system clock
    input wire logic reset_i,                                 // power-on reset, async high
    input wire logic manual_reset_i,                          // manual reset, sync high
    input wire logic [pbm_pkg::PBM_ADDR_W-1:0] avs_address_i, // word address
    input wire logic avs_read_i,                              // read request
    input wire logic avs_write_i,                             // write request
    input wire logic [pbm_pkg::PBM_DATA_W-1:0] avs_writedata_i, // write data
    input wire logic [pbm_pkg::PBM_BE_W-1:0] avs_byteenable_i,  // byte lanes
    output logic [pbm_pkg::PBM_DATA_W-1:0] avs_readdata_o,    // read data
    output logic avs_waitrequest_o,                           // stall request
    input wire logic [pbm_pkg::PBM_PINS-1:0] gpio_do_i,       // port data out
    input wire logic [pbm_pkg::PBM_PINS-1:0] gpio_oe_i,       // port direction, 1 out
    output logic [pbm_pkg::PBM_PINS-1:0] gpio_di_o,           // pin levels to port
    input wire logic [5:0] timer_capcomp_do_i,                // timer2..4 a/b out
    input wire logic [5:0] timer_capcomp_oe_i,                // timer2..4 a/b enable
    output logic [5:0] timer_capcomp_di_o,                    // timer2..4 a/b capture
    input wire logic timer4_compare_out_xa_i,                 // compare out, pin 6
    input wire logic timer4_compare_out_xb_i,                 // compare out, pin 7
    output logic timer_ext_clock_c_o,                         // clock in from pin 6
    output logic timer_ext_clock_d_o,                         // clock in from pin 7
    input wire logic [pbm_pkg::PBM_PINS-1:0] pattern_out_i,   // timing pattern data
    input wire logic [pbm_pkg::PBM_PINS-1:0] port_pin_i,      // pin levels
    output logic [pbm_pkg::PBM_PINS-1:0] port_pin_o,          // pin drive levels
    output logic [pbm_pkg::PBM_PINS-1:0] port_pin_oe_n_o,     // low while driving
    input wire logic chip_select_one_n_i,                     // chip select one
    input wire logic chip_select_three_n_i,                   // chip select three
    input wire logic upper_column_strobe_n_i,                 // upper column strobe
    input wire logic lower_column_strobe_n_i,                 // lower column strobe
    output logic [1:0] strobe_pin_n_o                         // [1] upper, [0] lower pin
);
    import pbm_pkg::*;

    pbm_bus_state_e state_q, state_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] port_sel_q, port_sel_d;
    logic [3:0] strobe_fld_q, strobe_fld_d;
    logic [1:0] strobe_pin_q, strobe_pin_d;
    logic [7:0] pin_meta_q, pin_sync_q;
    logic [7:0] alt_do_w, alt_oe_w, alt_di_w, clk_in_w;
    logic [1:0] upper_mode_w, lower_mode_w;
    logic wr_en_w, req_w;

    // *************************************************************
    // pin input synchroniser
    // *************************************************************
    // pins are asynchronous; only the second stage is ever looked at
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            pin_meta_q <= 8'h00;
            pin_sync_q <= 8'h00;
        end
        else
        begin
            pin_meta_q <= port_pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // *************************************************************
    // avalon slave and registers
    // *************************************************************
    assign req_w = avs_read_i | avs_write_i;
    assign wr_en_w = avs_write_i && state_q == PBM_ACK;
    assign avs_waitrequest_o = req_w && state_q != PBM_ACK;
    assign avs_readdata_o = rdata_q;
    assign upper_mode_w = strobe_fld_q[PBM_UPPER_STROBE_LSB-PBM_STROBE_FLD_LSB +: 2];
    assign lower_mode_w = strobe_fld_q[PBM_LOWER_STROBE_LSB-PBM_STROBE_FLD_LSB +: 2];

    // one wait cycle per access; read data captured on the way in
    always_comb
    begin
        state_d = state_q;
        rdata_d = rdata_q;
        port_sel_d = port_sel_q;
        strobe_fld_d = strobe_fld_q;
        unique case (state_q)
            PBM_IDLE:
            begin
                if (req_w)
                begin
                    state_d = PBM_ACK;
                    if (avs_read_i && avs_address_i == PBM_PORTSEL_IDX)
                        rdata_d = {16'h0000, port_sel_q};
                    else if (avs_read_i && avs_address_i == PBM_STROBE_IDX)
                        rdata_d = {16'h0000, strobe_fld_q, PBM_STROBE_RSVD_ONES};
                    else
                        rdata_d = 32'h0000_0000;
                end
            end
            PBM_ACK:
            begin
                state_d = PBM_IDLE;
            end
        endcase
        // manual reset only restarts the handshake, never the registers
        if (manual_reset_i)
            state_d = PBM_IDLE;
        if (wr_en_w && avs_address_i == PBM_PORTSEL_IDX)
        begin
            if (avs_byteenable_i[0])
                port_sel_d[7:0] = avs_writedata_i[7:0];
            if (avs_byteenable_i[1])
                port_sel_d[15:8] = avs_writedata_i[15:8];
        end
        // reserved low bits are not stored, so a careless write cannot clear them
        if (wr_en_w && avs_address_i == PBM_STROBE_IDX && avs_byteenable_i[1])
            strobe_fld_d = avs_writedata_i[15:12];
    end

    // strobe pins follow their fields; reserved codes hold the pin inactive
    always_comb
    begin
        unique case (upper_mode_w)
            PBM_STROBE_CS: strobe_pin_d[1] = chip_select_one_n_i;
            PBM_STROBE_CAS: strobe_pin_d[1] = upper_column_strobe_n_i;
            default: strobe_pin_d[1] = 1'b1;
        endcase
        unique case (lower_mode_w)
            PBM_STROBE_CS: strobe_pin_d[0] = chip_select_three_n_i;
            PBM_STROBE_CAS: strobe_pin_d[0] = lower_column_strobe_n_i;
            default: strobe_pin_d[0] = 1'b1;
        endcase
    end

    // only power-on reset reaches the registers
    always_ff @(posedge mclk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            state_q <= PBM_IDLE;
            rdata_q <= 32'h0000_0000;
            port_sel_q <= PBM_PORTSEL_RST;
            strobe_fld_q <= PBM_STROBE_RST[15:12];
            strobe_pin_q <= 2'h3;
        end
        else
        begin
            state_q <= state_d;
            rdata_q <= rdata_d;
            port_sel_q <= port_sel_d;
            strobe_fld_q <= strobe_fld_d;
            strobe_pin_q <= strobe_pin_d;
        end
    end

    assign strobe_pin_n_o = strobe_pin_q;

    // *************************************************************
    // pin cells
    // *************************************************************
    // pins 6 and 7 carry pure compare outputs, so their drive is always on in mode 10
    assign alt_do_w = {timer4_compare_out_xb_i, timer4_compare_out_xa_i, timer_capcomp_do_i};
    assign alt_oe_w = {2'b11, timer_capcomp_oe_i};
    assign timer_capcomp_di_o = alt_di_w[5:0];
    assign timer_ext_clock_c_o = clk_in_w[6];
    assign timer_ext_clock_d_o = clk_in_w[7];

    // one cell per pin, mode from bits 2n+1:2n
    for (genvar n = 0; n < PBM_PINS; n++)
    begin : g_pin
        pbm_pin_cell #(
            .CLK_IN_EN(n >= 6)
        ) u_cell (
            .mclk_i(mclk_i),
            .reset_i(reset_i),
            .mode_i(port_sel_q[PBM_MODE_W*n +: PBM_MODE_W]),
            .gpio_do_i(gpio_do_i[n]),
            .gpio_oe_i(gpio_oe_i[n]),
            .alt_do_i(alt_do_w[n]),
            .alt_oe_i(alt_oe_w[n]),
            .pattern_i(pattern_out_i[n]),
            .pin_sync_i(pin_sync_q[n]),
            .pin_o(port_pin_o[n]),
            .pin_oe_n_o(port_pin_oe_n_o[n]),
            .gpio_di_o(gpio_di_o[n]),
            .alt_di_o(alt_di_w[n]),
            .clk_in_o(clk_in_w[n])
        );
    end

    // *************************************************************
    // checks
    // *************************************************************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    sequence s_bus_req;
        req_w && state_q == PBM_IDLE && !manual_reset_i;
    endsequence
    sequence s_bus_done;
        state_q == PBM_ACK ##1 state_q == PBM_IDLE;
    endsequence
    sequence s_wr_ack(logic [3:0] idx);
        state_q == PBM_ACK && avs_write_i && avs_address_i == idx;
    endsequence

    bus_answer_a: assert property (s_bus_req |=> s_bus_done)
        else $error("bus access not answered in one wait cycle");
    port_write_a: assert property (
        s_wr_ack(PBM_PORTSEL_IDX) and avs_byteenable_i[1:0] == 2'b11
        |=> port_sel_q == $past(avs_writedata_i[15:0]))
        else $error("port select write lost");
    strobe_write_a: assert property (
        s_wr_ack(PBM_STROBE_IDX) and avs_byteenable_i[1]
        |=> strobe_fld_q == $past(avs_writedata_i[15:12]))
        else $error("strobe field write lost");
    strobe_read_a: assert property (
        state_q == PBM_ACK && avs_read_i && $past(avs_address_i) == PBM_STROBE_IDX
        |-> avs_readdata_o == {16'h0000, strobe_fld_q, PBM_STROBE_RSVD_ONES})
        else $error("strobe read data wrong");
    power_on_a: assert property (
        $fell(reset_i) |-> strobe_fld_q == PBM_STROBE_FLD_RST && port_sel_q == PBM_PORTSEL_RST)
        else $error("wrong value after power-on");
    manual_keep_a: assert property (
        manual_reset_i && !wr_en_w |=> $stable(port_sel_q) && $stable(strobe_fld_q))
        else $error("manual reset disturbed a register");
    upper_strobe_a: assert property (
        upper_mode_w == PBM_STROBE_CAS |=> strobe_pin_n_o[1] == $past(upper_column_strobe_n_i))
        else $error("upper strobe pin not following field");
    lower_strobe_a: assert property (
        lower_mode_w == PBM_STROBE_CS |=> strobe_pin_n_o[0] == $past(chip_select_three_n_i))
        else $error("lower strobe pin not following field");
    // the cell registers the synchronised level once, so one edge of latency
    pin7_clock_a: assert property (
        port_sel_q[15:14] == PBM_MODE_ALT_IN |=> timer_ext_clock_d_o == $past(pin_sync_q[7]))
        else $error("pin 7 clock input not routed");
    pin6_compare_a: assert property (
        port_sel_q[13:12] == PBM_MODE_ALT |=> port_pin_o[6] == $past(timer4_compare_out_xa_i)
        && !port_pin_oe_n_o[6])
        else $error("pin 6 compare output not driven");
    pin7_compare_a: assert property (
        port_sel_q[15:14] == PBM_MODE_ALT |=> port_pin_o[7] == $past(timer4_compare_out_xb_i)
        && !port_pin_oe_n_o[7])
        else $error("pin 7 compare output not driven");
    pin6_clock_a: assert property (
        port_sel_q[13:12] == PBM_MODE_ALT_IN |=> timer_ext_clock_c_o == $past(pin_sync_q[6]))
        else $error("pin 6 clock input not routed");
    clock_idle_a: assert property (
        port_sel_q[15:14] != PBM_MODE_ALT_IN |=> !timer_ext_clock_d_o)
        else $error("pin 7 clock input leaks");
    // port logic sees the pin in every mode
    port_in_a: assert property (gpio_di_o == $past(pin_sync_q))
        else $error("pin level lost");

    // strobe pins: chosen source, or held high on a reserved code
    upper_cs_a: assert property (
        upper_mode_w == PBM_STROBE_CS |=> strobe_pin_n_o[1] == $past(chip_select_one_n_i))
        else $error("upper pin not on chip select");
    lower_cas_a: assert property (
        lower_mode_w == PBM_STROBE_CAS |=> strobe_pin_n_o[0] == $past(lower_column_strobe_n_i))
        else $error("lower pin not on column strobe");
    upper_idle_a: assert property (
        upper_mode_w != PBM_STROBE_CS && upper_mode_w != PBM_STROBE_CAS |=> strobe_pin_n_o[1])
        else $error("upper pin active on reserved code");
    lower_idle_a: assert property (
        lower_mode_w != PBM_STROBE_CS && lower_mode_w != PBM_STROBE_CAS |=> strobe_pin_n_o[0])
        else $error("lower pin active on reserved code");

    sequence s_rd_ack(logic [3:0] idx);
        state_q == PBM_ACK && avs_read_i && avs_address_i == idx;
    endsequence

    // registers move only on an answered write
    bus_stall_a: assert property (s_bus_req |-> avs_waitrequest_o)
        else $error("request answered without wait");
    port_read_a: assert property (
        s_rd_ack(PBM_PORTSEL_IDX) |-> avs_readdata_o == {16'h0000, port_sel_q})
        else $error("port select read data wrong");
    unmapped_read_a: assert property (state_q == PBM_ACK && avs_read_i
        && avs_address_i > PBM_STROBE_IDX |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    read_hold_a: assert property (state_q == PBM_ACK |=> $stable(avs_readdata_o))
        else $error("read data moved");
    idle_hold_a: assert property (
        state_q == PBM_IDLE |=> $stable(port_sel_q) && $stable(strobe_fld_q))
        else $error("register changed without write");
    port_lane_a: assert property (
        s_wr_ack(PBM_PORTSEL_IDX) and avs_byteenable_i[1:0] == 2'b10
        |=> port_sel_q == {$past(avs_writedata_i[15:8]), $past(port_sel_q[7:0])})
        else $error("port select lane write wrong");
    strobe_lane_a: assert property (
        s_wr_ack(PBM_STROBE_IDX) and !avs_byteenable_i[1] |=> $stable(strobe_fld_q))
        else $error("strobe fields moved on low lane");
endmodule

// ---- verif/test_port_b_low_and_strobe_pin_mux.sv ----
// self-checking bench for the port-b low-half and strobe pin selector
// assumes pbm_pkg and pbm_pin_select compiled first; bench drives every input
module test_port_b_low_and_strobe_pin_mux;
    timeunit 1ns;
    timeprecision 1ns;
    import pbm_pkg::*;

    // *************************************************************
    // stimulus, model state and dut
    // *************************************************************
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic manual_reset_i = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [3:0] be = 4'h0;
    logic [31:0] rdat;
    logic wait_o;
    logic [7:0] gdo = 8'h0, goe = 8'h0, pat = 8'h0, pin_in = 8'h0, gdi, pin_o, oe_n;
    logic [5:0] cdo = 6'h0, coe = 6'h0, cdi;
    logic xa = 1'b0, xb = 1'b0, clkc, clkd;
    logic [3:0] cs = 4'hF; // [0] cs one, [1] cs three, [2] upper cas, [3] lower cas
    logic [1:0] spin;
    logic [15:0] psel; // model of the port select register
    logic [3:0] strb;  // model of the stored strobe fields
    int seed = 32'hce5f;
    int mismatches = 0;
    int comparisons = 0;

    pbm_pin_select u_dut
    (
        .mclk_i(mclk_i), .reset_i(reset_i), .manual_reset_i(manual_reset_i),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
        .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o),
        .gpio_do_i(gdo), .gpio_oe_i(goe), .gpio_di_o(gdi),
        .timer_capcomp_do_i(cdo), .timer_capcomp_oe_i(coe), .timer_capcomp_di_o(cdi),
        .timer4_compare_out_xa_i(xa), .timer4_compare_out_xb_i(xb),
        .timer_ext_clock_c_o(clkc), .timer_ext_clock_d_o(clkd),
        .pattern_out_i(pat), .port_pin_i(pin_in), .port_pin_o(pin_o), .port_pin_oe_n_o(oe_n),
        .chip_select_one_n_i(cs[0]), .chip_select_three_n_i(cs[1]),
        .upper_column_strobe_n_i(cs[2]), .lower_column_strobe_n_i(cs[3]),
        .strobe_pin_n_o(spin)
    );

    // 10 MHz clock
    initial
    begin
        forever #50 mclk_i = ~mclk_i;
    end

    // *************************************************************
    // shared tasks
    // *************************************************************
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // avalon cycle: hold everything until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] lanes, output logic [31:0] q);
        int n;
        @(posedge mclk_i);
        adr <= a;
        wr <= w;
        rd <= !w;
        wdat <= d;
        be <= lanes;
        n = 0;
        do
        begin
            @(posedge mclk_i);
            n++;
        end
        while (wait_o !== 1'b0 && n < 20);
        q = rdat;
        check("bus_answer", 32'h0, 32'(wait_o));
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [3:0] a, input logic [15:0] d, input logic [3:0] lanes);
        logic [31:0] q;
        bus(1'b1, a, {16'h0, d}, lanes, q);
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input string name);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, 4'hF, q);
        check(name, exp, q);
    endtask

    // fresh random levels on every peripheral and pin input
    task automatic stir();
        @(posedge mclk_i);
        gdo <= 8'($random(seed));
        goe <= 8'($random(seed));
        pat <= 8'($random(seed));
        pin_in <= 8'($random(seed));
        cdo <= 6'($random(seed));
        coe <= 6'($random(seed));
        xa <= 1'($random(seed));
        xb <= 1'($random(seed));
        cs <= 4'($random(seed));
    endtask

    // pin data of a clock-input pin is masked; the cell drives it low with the pin released
    task automatic check_pins();
        logic [7:0] e_o, e_oe, mask;
        logic [5:0] e_c;
        logic [1:0] m;
        logic [1:0] e_ck;
        for (int i = 0; i < 8; i++)
        begin
            m = 2'(psel >> (2 * i));
            e_o[i] = (m == 2'h0) ? gdo[i] : (m == 2'h3) ? pat[i] : (m == 2'h1) ? 1'b0 :
                     (i == 7) ? xb : (i == 6) ? xa : cdo[i];
            e_oe[i] = (m == 2'h0) ? !goe[i] : (m == 2'h1) ? 1'b1 :
                      (m == 2'h2 && i < 6) ? !coe[i] : 1'b0;
            mask[i] = !(m == 2'h1 && i > 5);
            if (i < 6)
                e_c[i] = (m == 2'h2) ? pin_in[i] : 1'b0;
        end
        e_ck[1] = (psel[15:14] == 2'h1) ? pin_in[7] : 1'b0;
        e_ck[0] = (psel[13:12] == 2'h1) ? pin_in[6] : 1'b0;
        check("port_pin_o", 32'(e_o & mask), 32'(pin_o & mask));
        check("port_pin_oe_n_o", 32'(e_oe), 32'(oe_n));
        check("gpio_di_o", 32'(pin_in), 32'(gdi));
        check("timer_capcomp_di_o", 32'(e_c), 32'(cdi));
        check("timer_ext_clock", 32'(e_ck), 32'({clkd, clkc}));
    endtask

    task automatic check_strobe();
        logic [1:0] e;
        e[1] = (strb[3:2] == PBM_STROBE_CS) ? cs[0] : (strb[3:2] == PBM_STROBE_CAS) ? cs[2] : 1'b1;
        e[0] = (strb[1:0] == PBM_STROBE_CS) ? cs[1] : (strb[1:0] == PBM_STROBE_CAS) ? cs[3] : 1'b1;
        check("strobe_pin_n_o", 32'(e), 32'(spin));
    endtask

    task automatic complete_run();
        if (mismatches == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // *************************************************************
    // scenarios
    // *************************************************************
    initial
    begin
        logic [15:0] d;
        repeat (20) @(posedge mclk_i);
        reset_i <= 1'b0;
        psel = PBM_PORTSEL_RST;
        strb = PBM_STROBE_FLD_RST;
        rchk(PBM_PORTSEL_IDX, 32'h0, "port_sel_reset");
        rchk(PBM_STROBE_IDX, 32'h5FFF, "strobe_reset");
        // each mode on all pins (01 turned into 11 on pins 5..0), then random mixes of modes
        for (int k = 0; k < 8; k++)
        begin
            d = (k < 4) ? {8{2'(k)}} : 16'($random(seed));
            d[11:0] = d[11:0] | ((d[11:0] & 12'h555) << 1);
            wreg(PBM_PORTSEL_IDX, d, 4'h3);
            psel = d;
            rchk(PBM_PORTSEL_IDX, 32'(d), "port_sel_rw");
            stir();
            repeat (5) @(posedge mclk_i);
            check_pins();
        end
        // high lane only: low byte must keep its modes
        wreg(PBM_PORTSEL_IDX, 16'hFFFF, 4'h2);
        psel[15:8] = 8'hFF;
        rchk(PBM_PORTSEL_IDX, 32'(psel), "port_sel_lane");
        // all sixteen strobe field pairs, fixed bits written as ones
        for (int k = 0; k < 16; k++)
        begin
            strb = 4'(k);
            wreg(PBM_STROBE_IDX, {strb, PBM_STROBE_RSVD_ONES}, 4'h3);
            rchk(PBM_STROBE_IDX, {16'h0, strb, 12'hFFF}, "strobe_rw");
            stir();
            repeat (2) @(posedge mclk_i);
            check_strobe();
        end
        wreg(PBM_STROBE_IDX, 16'h0FFF, 4'h1);
        rchk(PBM_STROBE_IDX, {16'h0, strb, 12'hFFF}, "strobe_lane0");
        // manual reset keeps both registers
        @(posedge mclk_i);
        manual_reset_i <= 1'b1;
        @(posedge mclk_i);
        manual_reset_i <= 1'b0;
        rchk(PBM_PORTSEL_IDX, 32'(psel), "port_sel_manual");
        rchk(PBM_STROBE_IDX, {16'h0, strb, 12'hFFF}, "strobe_manual");
        // unmapped word: answered, reads zero, write lost
        wreg(4'h7, 16'hFFFF, 4'hF);
        rchk(4'h7, 32'h0, "unmapped");
        rchk(PBM_PORTSEL_IDX, 32'(psel), "port_sel_after_unmapped");
        // second power-on reset in mid-run
        @(posedge mclk_i);
        reset_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        reset_i <= 1'b0;
        psel = PBM_PORTSEL_RST;
        strb = PBM_STROBE_FLD_RST;
        rchk(PBM_PORTSEL_IDX, 32'h0, "port_sel_rereset");
        rchk(PBM_STROBE_IDX, 32'h5FFF, "strobe_rereset");
        stir();
        repeat (5) @(posedge mclk_i);
        check_pins();
        check_strobe();
        complete_run();
    end

    // watchdog: the run needs well under a thousand cycles
    initial
    begin
        #2000000;
        mismatches++;
        complete_run();
    end
endmodule
